// >>> dv/i2c_bus_peer.sv
// bus peer: another master or slave pulling scl and sda through open drain
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_peer (
  output var logic scl,  // 1 = released, pull-up
  output var logic sda   // 1 = released, pull-up
);
  localparam int HALF = 160;  // half of a 320 ns link clock

  // idle bus: both lines released, clock stands still
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // start: sda falls while scl high, then clock held low
  task start_cond;
    #13 sda = 1'b0;
    #HALF scl = 1'b0;
    #HALF;
  endtask : start_cond

  // one clocked bit, data released to pull-up once clock is low
  task send_bit(input logic b);
    #13 sda = b;
    #HALF scl = 1'b1;
    #HALF scl = 1'b0;
    sda = 1'b1;
  endtask : send_bit

  // stop: sda rises while scl high, bus left idle
  task stop_cond;
    #13 sda = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda = 1'b1;
  endtask : stop_cond
endmodule : i2c_bus_peer

`default_nettype wire

// >>> dv/i2c_status_flag_logic_properties.sv
// checker: concurrent properties on the ports of the status flag block
`timescale 1ns/10ps
`default_nettype none

module i2c_status_flag_logic_properties (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   hsel,
  input wire logic [7:0]             haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire i2c_status_pkg::mode_s  mode,
  input wire i2c_status_pkg::engine_s engine,
  input wire logic                   scl_in,
  input wire logic                   sda_in,
  input wire logic                   start_request,
  input wire logic                   stop_request,
  input wire logic                   arb_lost_event,
  input wire logic                   ack_drive_value,
  input wire logic                   transfer_interrupt_flag,
  input wire logic                   bus_occupied_flag
);
  import i2c_status_pkg::*;

  // ****************************************************************
  // data phase tracking
  // ****************************************************************
  logic      wr_q;  // write data phase to the status word
  logic      rd_q;  // read data phase of the status word
  wire logic hit = hsel && hready && htrans[1] && (haddr == STATUS_OFFSET);

  // remember which kind of status access is in its data phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= hit && hwrite;
      rd_q <= hit && !hwrite;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ****************************************************************
  // properties
  // ****************************************************************
  fixed_bits_a: assert property (
    rd_q |-> hrdata[5:4] == 2'h3 && hrdata[31:8] == 24'h0) else $error("fixed bits wrong");
  xfer_irq_a: assert property (
    engine.xfer_end && (mode.master_select || mode.format_select) |=> transfer_interrupt_flag)
    else $error("transfer end did not raise flag");
  lost_irq_a: assert property (
    $rose(arb_lost_event) |-> transfer_interrupt_flag) else $error("lost without flag");
  start_req_a: assert property (
    wr_q && mode.master_select && hwdata[7] && !hwdata[5] |=> start_request)
    else $error("start not requested");
  stop_req_a: assert property (
    wr_q && mode.master_select && !hwdata[7] && !hwdata[5] |=> stop_request)
    else $error("stop not requested");
  guard_hold_a: assert property (
    wr_q && (hwdata[5] || !mode.master_select) |=> !start_request && !stop_request)
    else $error("request despite guard or slave");
  busy_set_a: assert property (
    $fell(sda_in) && scl_in |-> ##[1:6] bus_occupied_flag) else $error("busy not set");
  busy_clear_a: assert property (
    $rose(sda_in) && scl_in |-> ##[1:6] !bus_occupied_flag) else $error("busy not cleared");
  ack_drive_a: assert property (
    wr_q |-> ##2 ack_drive_value == $past(hwdata[0], 2)) else $error("ack drive wrong");
endmodule : i2c_status_flag_logic_properties

bind i2c_status_flag_logic i2c_status_flag_logic_properties u_props (.clk, .rst_b, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .mode, .engine, .scl_in, .sda_in,
  .start_request, .stop_request, .arb_lost_event, .ack_drive_value,
  .transfer_interrupt_flag, .bus_occupied_flag);

`default_nettype wire

// >>> dv/i2c_status_flag_logic_tb.sv
// testbench: status flag block with a bus peer and an ahb-lite master
`timescale 1ns/10ps
`default_nettype none

module i2c_status_flag_logic_tb;
  import i2c_status_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic         clk = 1'b0;                 // 25 MHz
  logic         rst_b = 1'b0;
  logic         hsel = 1'b0;
  logic         hwrite = 1'b0;
  logic [7:0]   haddr = 8'h00;
  logic [1:0]   htrans = 2'h0;
  logic [2:0]   hsize = 3'h2;               // whole words only
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  mode_s        mode = mode_s'(0);
  engine_s      engine = engine_s'(3);      // internal lines released
  data_access_s data_access = '0;
  logic [6:0]   own_address_field = 7'h5A;
  logic         start_request;
  logic         stop_request;
  logic         arb_lost_event;
  logic         ack_drive_value;
  logic         transfer_interrupt_flag;
  logic         bus_occupied_flag;
  wire logic    peer_scl;
  wire logic    peer_sda;
  wire logic    scl_in = peer_scl & engine.scl_drive;  // wired-and bus
  wire logic    sda_in = peer_sda & engine.sda_drive;
  int           bad_count = 0;
  int           check_count = 0;
  int           n_start = 0;                // start pulses seen
  int           n_stop = 0;                 // stop pulses seen
  int           n_lost = 0;                 // lost pulses seen

  always #20 clk = ~clk;

  i2c_status_flag_logic dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mode, .engine, .data_access,
    .own_address_field, .scl_in, .sda_in, .start_request, .stop_request, .arb_lost_event,
    .ack_drive_value, .transfer_interrupt_flag, .bus_occupied_flag);
  i2c_bus_peer peer (.scl(peer_scl), .sda(peer_sda));

  // count one-cycle pulses
  always @(posedge clk) begin
    if (start_request === 1'b1) n_start++;
    if (stop_request === 1'b1) n_stop++;
    if (arb_lost_event === 1'h1) n_lost++;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task report_and_stop;
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // single transfer; waits on hreadyout, never a fixed count
  task ahb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task wr(input logic [7:0] d);
    logic [31:0] q;
    ahb(1'b1, STATUS_OFFSET, d, q);
  endtask : wr

  task st(output logic [31:0] q);
    ahb(1'b0, STATUS_OFFSET, 8'h00, q);
  endtask : st

  // reset held 8 cycles; also exercises a second reset in mid-run
  task do_reset(input logic [3:0] m);
    @(posedge clk);
    rst_b  <= 1'b0;
    mode   <= m;
    engine <= engine_s'(3);
    repeat (8) @(posedge clk);
    rst_b  <= 1'b1;
    n_start = 0;
    n_stop  = 0;
  endtask : do_reset

  // p = {transfer end, data write, data read}, one-cycle strobes
  task pulse(input logic [2:0] p);
    @(posedge clk);
    engine.xfer_end <= p[2];
    data_access     <= p[1:0];
    @(posedge clk);
    engine.xfer_end <= 1'b0;
    data_access     <= 2'h0;
  endtask : pulse

  task first(input logic [7:0] b);
    @(posedge clk);
    engine.first_byte_end <= 1'b1;
    engine.rx_byte        <= b;
    @(posedge clk);
    engine.first_byte_end <= 1'b0;
  endtask : first

  // line changes reach the flags after the synchroniser lag
  task settle;
    repeat (4) @(posedge clk);
  endtask : settle

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_regs;
    logic [31:0] q;
    do_reset(4'b0000);
    st(q);
    check("status reset", q, 32'h30);
    wr(8'hFF);
    st(q);
    check("ones written", q, 32'h31);
    wr(8'h40);
    settle;
    check("slave stop", n_stop + n_start, 0);
    ahb(1'b0, 8'h04, 8'h00, q);
    check("unmapped read", q, 32'h0);
  endtask : t_regs

  task t_master;
    logic [31:0] q;
    do_reset(4'b1100);
    pulse(3'b100);
    wr(8'h20);
    st(q);
    check("unarmed clear", q[6], 1'b1);
    wr(8'h20);
    st(q);
    check("armed clear", q[6], 1'b0);
    wr(8'hA0);
    wr(8'h80);
    wr(8'h00);
    settle;
    check("start count", n_start, 1);
    check("stop count", n_stop, 1);
  endtask : t_master

  task t_slave;
    logic [31:0] q;
    do_reset(4'b0010);
    pulse(3'b100);
    st(q);
    check("free format flag", q[6], 1'b1);
    do_reset(4'b0000);
    first({own_address_field, 1'b0});
    st(q);
    check("own match", q, 32'h74);
    wr(8'h24);
    pulse(3'b100);
    st(q);
    check("session transfer", q, 32'h74);
    pulse(3'b001);
    st(q);
    check("match read clear", q, 32'h70);
    wr(8'h20);
    first(8'h00);
    st(q);
    check("general call", q, 32'h76);
    pulse(3'b010);
    st(q);
    check("rx write keeps", q, 32'h76);
    pulse(3'b001);
    st(q);
    check("call read clear", q, 32'h70);
    wr(8'h20);
    peer.start_cond;
    settle;
    st(q);
    check("busy on start", q[7], 1'b1);
    peer.stop_cond;
    settle;
    pulse(3'b100);
    st(q);
    check("session closed", q, 32'h30);
  endtask : t_slave

  task t_arb;
    logic [31:0] q;
    do_reset(4'b1100);
    peer.start_cond;
    settle;
    st(q);
    check("clock lost", q, 32'hF8);
    pulse(3'b010);
    st(q);
    check("tx write clear", q, 32'hF0);
    fork // read after the bit, once scl is low again
      peer.send_bit(1'b0);
      begin
        repeat (8) @(posedge clk);
        st(q);
      end
    join
    check("data lost", q[3], 1'b1);
    settle;
    check("lost count", n_lost, 3);
  endtask : t_arb

  task t_ack;
    logic [31:0] q;
    do_reset(4'b0100);
    @(posedge clk);
    engine.ack_slot <= 1'b1;
    peer.send_bit(1'b1);
    settle;
    wr(8'h20);
    st(q);
    check("captured ack", q[0], 1'b1);
    @(posedge clk);
    mode <= mode_s'(0);
    st(q);
    check("software ack", q[0], 1'b0);
    wr(8'h21);
    st(q);
    check("software ack set", q[0], 1'b1);
    check("ack drive", ack_drive_value, 1'b1);
  endtask : t_ack

  initial begin
    t_regs;
    t_master;
    t_slave;
    t_arb;
    t_ack;
    report_and_stop;
  end

  // watchdog: the whole run needs far fewer than 5000 cycles
  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule : i2c_status_flag_logic_tb

`default_nettype wire

// >>> rtl/i2c_status_flag_logic.sv
// status and start/stop condition control of an i2c bus interface, ahb-lite register slave
//
// Behaviour
// - transfer flag clears by read-one then write-zero
// - master: flag set on transfer end, arbitration loss
// - slave addressed: flag on match and later transfers
// - slave general call: flag on call, later transfers
// - slave non-addressing: flag on every transfer end
// - master write busy=1 guard=0 issues start
// - master write busy=0 guard=0 issues stop
// - guard bit reads one, stores nothing
// - bit four reserved, reads one
// - arbitration loss sets lost and transfer flags
// - sda mismatch at scl rise means lost
// - internal scl high at bus fall means lost
// - lost flag: read-clear or data access clear
// - address match on own or general address
// - match flag: read-clear or data access clear
// - general call flag on first byte zero
// - call flag: read-clear or data access clear
// - transmit: capture receiver acknowledge into bit
// - receive: drive software acknowledge in slot
// - ack read: bus value transmit, software receive
// - busy set on start, cleared on stop
// - busy writes ignored in slave mode
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module i2c_status_flag_logic (
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  // ahb-lite slave
  input  wire logic                                hsel,
  input  wire logic [i2c_status_pkg::ADDR_WIDTH-1:0] haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [i2c_status_pkg::DATA_WIDTH-1:0] hwdata,
  input  wire logic                                hready,
  output logic      [i2c_status_pkg::DATA_WIDTH-1:0] hrdata,
  output logic                                     hreadyout,
  output logic                                     hresp,
  // control register and shift engine side
  input  wire i2c_status_pkg::mode_s               mode,
  input  wire i2c_status_pkg::engine_s             engine,
  input  wire i2c_status_pkg::data_access_s        data_access,
  input  wire logic [6:0]                          own_address_field,
  // bus pins, asynchronous
  input  wire logic                                scl_in,
  input  wire logic                                sda_in,
  // outputs to the shift engine and control block
  output logic                                     start_request,
  output logic                                     stop_request,
  output logic                                     arb_lost_event,
  output logic                                     ack_drive_value,
  output logic                                     transfer_interrupt_flag,
  output logic                                     bus_occupied_flag
);
  import i2c_status_pkg::*;

  // *****************************************************************
  // pin synchronisers and edge finding
  // *****************************************************************
  logic       scl_meta;     // first stage, only read by scl_sync
  logic       scl_sync;     // stable scl
  logic       scl_prev;     // scl one cycle earlier
  logic       sda_meta;     // first stage, only read by sda_sync
  logic       sda_sync;     // stable sda
  logic       sda_prev;     // sda one cycle earlier
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;   // sda falling while scl high
  logic       stop_seen;    // sda rising while scl high

  // two flops before anything looks at the pins
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_meta <= 1'h1;
      scl_sync <= 1'h1;
      scl_prev <= 1'h1;
      sda_meta <= 1'h1;
      sda_sync <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  // scl must be high before and after so an scl edge is never taken as a condition
  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // *****************************************************************
  // ahb-lite address phase capture
  // *****************************************************************
  logic       addr_valid;   // address phase accepted this edge
  logic       dp_write;     // data phase pending: register write
  logic       hit_status;   // address decodes to the status register
  logic [7:0] status_view;  // byte as software reads it
  logic       status_read;  // read of the status register taken now

  assign addr_valid  = hsel & hready & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign hit_status  = (haddr == STATUS_OFFSET);
  assign status_read = addr_valid & ~hwrite & hit_status;
  // never stalls, never errors; unmapped words read zero, writes vanish
  assign hreadyout   = 1'h1;
  assign hresp       = HRESP_OKAY;

  // remember a pending write for its data phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dp_write <= 1'h0;
    end else if (hready) begin
      dp_write <= addr_valid & hwrite & hit_status;
    end
  end

  logic       wr_now;       // data phase of a status write
  logic [7:0] wr_byte;      // written byte, low lane
  assign wr_now  = dp_write;
  assign wr_byte = hwdata[7:0];

  // read data registered at the address edge so it stands in the data phase
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata <= '0;
    end else if (addr_valid & ~hwrite) begin
      hrdata <= hit_status ? {24'h000000, status_view} : '0;
    end
  end

  // *****************************************************************
  // flag storage
  // *****************************************************************
  logic ack_bus;       // acknowledge captured from the line
  logic ack_sw;        // acknowledge value set by software
  logic lost_flag;     // arbitration lost
  logic match_flag;    // own or general address recognised
  logic call_flag;     // general call recognised
  logic session_on;    // slave addressed since the last start/stop

  // which flags have been read as one and may now be cleared
  logic arm_irq;
  logic arm_lost;
  logic arm_match;
  logic arm_call;

  // guard bit and reserved bit are constants on read
  always_comb begin
    status_view                   = STATUS_RESET;
    status_view[BIT_BUS_OCCUPIED] = bus_occupied_flag;
    status_view[BIT_XFER_IRQ]     = transfer_interrupt_flag;
    status_view[BIT_ARB_LOST]     = lost_flag;
    status_view[BIT_ADDR_MATCH]   = match_flag;
    status_view[BIT_GEN_CALL]     = call_flag;
    // bus value in transmit, software value in receive
    status_view[BIT_ACK_VALUE]    = mode.direction_select ? ack_bus : ack_sw;
  end

  // *****************************************************************
  // event decode
  // *****************************************************************
  logic is_slave_rx;   // slave receive, addressing format
  logic addr_hit;      // first byte matches own address
  logic call_hit;      // first byte is the general call
  logic sda_lost;      // transmitted high, line low at scl rise
  logic scl_lost;      // internal scl high at bus scl fall
  logic arb_lost;      // either loss while master transmitting
  logic irq_set;       // any cause of the transfer flag
  logic data_clear;    // data register access that clears flags

  assign is_slave_rx = ~mode.master_select & ~mode.direction_select & ~mode.format_select;
  assign call_hit    = engine.first_byte_end & is_slave_rx
                     & (engine.rx_byte == {GENERAL_CALL_ADDR, 1'h0});
  assign addr_hit    = engine.first_byte_end & is_slave_rx
                     & (engine.rx_byte[7:1] == own_address_field);
  // the acknowledge bit is driven by the receiver, so it is not compared
  assign sda_lost    = scl_rise & engine.sda_drive & ~sda_sync & ~engine.ack_slot;
  assign scl_lost    = scl_fall & engine.scl_drive;
  assign arb_lost    = mode.master_select & mode.direction_select
                     & (sda_lost | scl_lost);
  assign data_clear  = (data_access.data_write & mode.direction_select)
                     | (data_access.data_read & ~mode.direction_select);

  // transfer flag causes per mode
  always_comb begin
    irq_set = 1'h0;
    if (mode.master_select) begin
      irq_set = engine.xfer_end | arb_lost;
    end else if (mode.format_select) begin
      irq_set = engine.xfer_end;
    end else begin
      // match or call opens a session; later transfers while it lasts
      irq_set = addr_hit | call_hit
              | (engine.xfer_end & session_on);
    end
  end

  // *****************************************************************
  // read arming: a read returning one allows the next zero write
  // *****************************************************************
  // a status write ends the arming unless a status read is taken in the same cycle, which wins; a fresh read is needed after it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arm_irq   <= 1'h0;
      arm_lost  <= 1'h0;
      arm_match <= 1'h0;
      arm_call  <= 1'h0;
    end else if (status_read) begin
      arm_irq   <= transfer_interrupt_flag;
      arm_lost  <= lost_flag;
      arm_match <= match_flag;
      arm_call  <= call_flag;
    end else if (wr_now) begin
      arm_irq   <= 1'h0;
      arm_lost  <= 1'h0;
      arm_match <= 1'h0;
      arm_call  <= 1'h0;
    end
  end

  // *****************************************************************
  // transfer interrupt flag
  // *****************************************************************
  // set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      transfer_interrupt_flag <= 1'h0;
    end else if (irq_set) begin
      transfer_interrupt_flag <= 1'h1;
    end else if (wr_now & arm_irq & ~wr_byte[BIT_XFER_IRQ]) begin
      transfer_interrupt_flag <= 1'h0;
    end
  end

  // *****************************************************************
  // arbitration lost flag
  // *****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lost_flag <= 1'h0;
    end else if (arb_lost) begin
      lost_flag <= 1'h1;
    end else if (data_clear | (wr_now & arm_lost & ~wr_byte[BIT_ARB_LOST])) begin
      lost_flag <= 1'h0;
    end
  end

  // one-cycle notice so the control block drops to slave receive
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arb_lost_event <= 1'h0;
    end else begin
      arb_lost_event <= arb_lost;
    end
  end

  // *****************************************************************
  // address match and general call flags
  // *****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      match_flag <= 1'h0;
    end else if (addr_hit | call_hit) begin
      match_flag <= 1'h1;
    end else if (data_clear | (wr_now & arm_match & ~wr_byte[BIT_ADDR_MATCH])) begin
      match_flag <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      call_flag <= 1'h0;
    end else if (call_hit) begin
      call_flag <= 1'h1;
    end else if (data_clear | (wr_now & arm_call & ~wr_byte[BIT_GEN_CALL])) begin
      call_flag <= 1'h0;
    end
  end

  // slave session: open from match until a start or stop is seen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      session_on <= 1'h0;
    end else if (start_seen | stop_seen) begin
      session_on <= 1'h0;
    end else if (addr_hit | call_hit) begin
      session_on <= 1'h1;
    end
  end

  // *****************************************************************
  // bus occupied flag and condition requests
  // *****************************************************************
  // follows the line only; software writes never store here
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bus_occupied_flag <= 1'h0;
    end else if (start_seen) begin
      bus_occupied_flag <= 1'h1;
    end else if (stop_seen) begin
      bus_occupied_flag <= 1'h0;
    end
  end

  logic cond_write;   // master write with the guard bit low
  assign cond_write = wr_now & mode.master_select & ~wr_byte[BIT_COND_GUARD];

  // one-cycle requests to the shift engine; slave writes do nothing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_request <= 1'h0;
      stop_request  <= 1'h0;
    end else begin
      start_request <= cond_write & wr_byte[BIT_BUS_OCCUPIED];
      stop_request  <= cond_write & ~wr_byte[BIT_BUS_OCCUPIED];
    end
  end

  // *****************************************************************
  // acknowledge bit
  // *****************************************************************
  // software value always writable; it is what receive mode sends
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_sw <= 1'h0;
    end else if (wr_now) begin
      ack_sw <= wr_byte[BIT_ACK_VALUE];
    end
  end

  // line sampled at the acknowledge clock rise while transmitting
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_bus <= 1'h0;
    end else if (scl_rise & engine.ack_slot & mode.direction_select & ~mode.serial_mode) begin
      ack_bus <= sda_sync;
    end
  end

  // value the engine puts on sda in the receive acknowledge slot
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_drive_value <= 1'h0;
    end else begin
      ack_drive_value <= ack_sw;
    end
  end

  // hsize is not decoded: only whole-word accesses reach this slave
  logic unused_size;
  assign unused_size = ^hsize;

endmodule : i2c_status_flag_logic

`default_nettype wire

// >>> rtl/i2c_status_pkg.sv
// package: register map, field positions and carriers for the i2c status flag block
`default_nettype none

package i2c_status_pkg;

  // *****************************************************************
  // register map
  // *****************************************************************
  localparam logic [7:0]  STATUS_OFFSET        = 8'h00;  // bus_status_flags_register byte address
  localparam logic [7:0]  STATUS_RESET         = 8'h30;  // guard and reserved bits read high
  localparam int          ADDR_WIDTH           = 8;      // decoded address bits
  localparam int          DATA_WIDTH           = 32;     // bus data width

  // *****************************************************************
  // field positions inside the status byte
  // *****************************************************************
  localparam int          BIT_BUS_OCCUPIED     = 7;
  localparam int          BIT_XFER_IRQ         = 6;
  localparam int          BIT_COND_GUARD       = 5;
  localparam int          BIT_RESERVED         = 4;
  localparam int          BIT_ARB_LOST         = 3;
  localparam int          BIT_ADDR_MATCH       = 2;
  localparam int          BIT_GEN_CALL         = 1;
  localparam int          BIT_ACK_VALUE        = 0;

  // *****************************************************************
  // bus constants
  // *****************************************************************
  localparam logic [1:0]  HTRANS_NONSEQ        = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ           = 2'h3;
  localparam logic        HRESP_OKAY           = 1'h0;
  localparam logic [6:0]  GENERAL_CALL_ADDR    = 7'h00;  // first byte 0x00 with r/w bit low
  localparam logic        RW_READ              = 1'h1;

  // *****************************************************************
  // carriers
  // *****************************************************************
  // operating mode from the control register block
  typedef struct packed {
    logic master_select;     // 1 = master
    logic direction_select;  // 1 = transmit
    logic format_select;     // 1 = non-addressing format
    logic serial_mode;       // 1 = no acknowledge slot
  } mode_s;

  // events and drive values from the shift engine
  typedef struct packed {
    logic       xfer_end;        // one-cycle pulse at end of a data transfer
    logic       first_byte_end;  // one-cycle pulse when first byte after start is in
    logic [7:0] rx_byte;         // received byte, valid with first_byte_end
    logic       ack_slot;        // level during the acknowledge bit
    logic       scl_drive;       // internal scl, 1 = released high
    logic       sda_drive;       // internal sda, 1 = released high
  } engine_s;

  // data register access strobes, one-cycle pulses
  typedef struct packed {
    logic data_write;
    logic data_read;
  } data_access_s;

endpackage : i2c_status_pkg

`default_nettype wire
